// ===== adcas_pkg.sv
// shared constants and types for the converter autoscan sequencer
package adcas_pkg;
    localparam int NUM_CH     = 8;
    localparam int RES_W      = 10;
    localparam int CH_W       = 3;
    // conv_control_reg bit positions
    localparam int PRE_HI_BIT = 7;
    localparam int PRE_LO_BIT = 6;
    localparam int DONE_BIT   = 4;
    localparam int START_BIT  = 3;
    localparam int CONT_BIT   = 2;
    localparam int RISE_BIT   = 1;
    localparam int FALL_BIT   = 0;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'h00;
    // sample is two bit periods, then ten bit periods
    localparam logic [3:0] SAMPLE_TICKS = 4'h2;
    localparam logic [3:0] CONV_TICKS   = 4'hC;
    localparam logic [RES_W-1:0] SAR_MSB = 10'h200;
    typedef enum logic [2:0] {
        ADCAS_IDLE  = 3'h0,
        ADCAS_SYNC  = 3'h1,
        ADCAS_CONV  = 3'h3,
        ADCAS_STORE = 3'h2,
        ADCAS_INIT  = 3'h6
    } adcas_state_e;
endpackage : adcas_pkg

// ===== adcas_result_mem.sv
// per-channel result buffer with registered read port
`timescale 1ns/1ps
`default_nettype none
module adcas_result_mem (
    input  wire logic                          clk_i,
    input  wire logic                          sys_rst_i,
    input  wire logic                          wr_en_i,
    input  wire logic [adcas_pkg::CH_W-1:0]    wr_ch_i,
    input  wire logic [adcas_pkg::RES_W-1:0]   wr_data_i,
    input  wire logic [adcas_pkg::CH_W-1:0]    rd_ch_i,
    output logic      [adcas_pkg::RES_W-1:0]   rd_data_o
);
    // contents are deliberately not reset
    logic [adcas_pkg::RES_W-1:0] mem_ff [adcas_pkg::NUM_CH];
    logic [adcas_pkg::RES_W-1:0] rd_ff;

    always_ff @(posedge clk_i) begin
        if (wr_en_i) begin
            mem_ff[wr_ch_i] <= wr_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rd_ff <= '0;
        end else begin
            rd_ff <= mem_ff[rd_ch_i];
        end
    end

    assign rd_data_o = rd_ff;
endmodule // adcas_result_mem
`default_nettype wire

// ===== adcas_sequencer.sv
// autoscan sequencer: prescaler, channel walk, successive approximation, flags
`timescale 1ns/1ps
`default_nettype none
module adcas_sequencer (
    input  wire logic                          clk_i,
    input  wire logic                          sys_rst_i,
    input  wire logic                          ctrl_wr_i,
    input  wire logic [7:0]                    ctrl_wdata_i,
    output logic      [7:0]                    conv_control_reg_o,
    input  wire logic                          mask_wr_i,
    input  wire logic [7:0]                    mask_wdata_i,
    output logic      [7:0]                    scan_select_mask_o,
    input  wire logic                          pwr_down_i,
    input  wire logic                          ext_start_pin_i,
    input  wire logic                          cmp_i,
    output logic      [adcas_pkg::RES_W-1:0]   dac_code_o,
    output logic      [adcas_pkg::CH_W-1:0]    ch_sel_o,
    output logic                               sample_o,
    input  wire logic [adcas_pkg::CH_W-1:0]    rd_ch_i,
    output logic      [adcas_pkg::RES_W-1:0]   rd_data_o
);
    adcas_pkg::adcas_state_e state_ff, nxt_state;
    logic [1:0]                  pre_sel_ff, nxt_pre_sel;
    logic                        done_ff, nxt_done;
    logic                        start_ff, nxt_start;
    logic                        pend_ff, nxt_pend;
    logic                        cont_ff, nxt_cont;
    logic                        rise_en_ff, nxt_rise_en;
    logic                        fall_en_ff, nxt_fall_en;
    logic [7:0]                  mask_ff, nxt_mask;
    logic [7:0]                  act_ff, nxt_act;
    logic [adcas_pkg::CH_W-1:0]  ch_ff, nxt_ch;
    logic [1:0]                  pre_cnt_ff, nxt_pre_cnt;
    logic [3:0]                  bit_cnt_ff, nxt_bit_cnt;
    logic [2:0]                  init_cnt_ff, nxt_init_cnt;
    logic [adcas_pkg::RES_W-1:0] sar_ff, nxt_sar;
    logic                        pin_s1_ff, pin_s2_ff, pin_s3_ff, pin_lvl_ff;
    logic                        tick, ext_edge, store_en, last_ch, go, lo_any, hi_any;
    logic [adcas_pkg::CH_W-1:0]  hi_ch, lo_ch;
    logic [3:0]                  bit_idx;
    // lowest set bit at or above a position
    function automatic logic [adcas_pkg::CH_W:0] find_from(input logic [7:0] m,
                                                           input logic [3:0] from);
        logic [adcas_pkg::CH_W:0] r = '0;
        for (int i = adcas_pkg::NUM_CH - 1; i >= 0; i--) begin
            if (m[i] && (4'(i) >= from)) begin
                r = {1'b1, 3'(i)};
            end
        end
        return r;
    endfunction
    // first flop feeds only the second; a level counts once stages two and three agree
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            pin_s1_ff  <= 1'b0;
            pin_s2_ff  <= 1'b0;
            pin_s3_ff  <= 1'b0;
            pin_lvl_ff <= 1'b0;
        end else begin
            pin_s1_ff  <= ext_start_pin_i;
            pin_s2_ff  <= pin_s1_ff;
            pin_s3_ff  <= pin_s2_ff;
            pin_lvl_ff <= (pin_s2_ff == pin_s3_ff) ? pin_s3_ff : pin_lvl_ff;
        end
    end
    assign ext_edge = (pin_s2_ff == pin_s3_ff) &&
                      ((rise_en_ff && pin_s3_ff && !pin_lvl_ff) ||
                       (fall_en_ff && !pin_s3_ff && pin_lvl_ff));
    // bit period is half the divisor, so the tick compares against the code itself
    assign tick     = (pre_cnt_ff == pre_sel_ff);
    assign bit_idx  = adcas_pkg::CONV_TICKS - 4'h1 - bit_cnt_ff;
    assign {lo_any, lo_ch} = find_from(mask_ff, 4'h0);
    assign {hi_any, hi_ch} = find_from(act_ff, 4'({1'b0, ch_ff}) + 4'h1);
    assign last_ch  = !hi_any;
    assign store_en = (state_ff == adcas_pkg::ADCAS_STORE);
    always_comb begin
        nxt_state    = state_ff;
        nxt_pre_sel  = pre_sel_ff;
        nxt_done     = done_ff;
        nxt_start    = start_ff;
        nxt_pend     = pend_ff;
        nxt_cont     = cont_ff;
        nxt_rise_en  = rise_en_ff;
        nxt_fall_en  = fall_en_ff;
        nxt_mask     = mask_wr_i ? mask_wdata_i : mask_ff;
        nxt_act      = act_ff;
        nxt_ch       = ch_ff;
        nxt_bit_cnt  = bit_cnt_ff;
        nxt_init_cnt = init_cnt_ff;
        nxt_sar      = sar_ff;
        nxt_pre_cnt  = tick ? 2'h0 : pre_cnt_ff + 2'h1; // free running gives start jitter
        go           = 1'b0;
        if (ctrl_wr_i) begin
            nxt_pre_sel = ctrl_wdata_i[adcas_pkg::PRE_HI_BIT:adcas_pkg::PRE_LO_BIT];
            nxt_cont    = ctrl_wdata_i[adcas_pkg::CONT_BIT];
            nxt_rise_en = ctrl_wdata_i[adcas_pkg::RISE_BIT];
            nxt_fall_en = ctrl_wdata_i[adcas_pkg::FALL_BIT];
            nxt_done    = done_ff && ctrl_wdata_i[adcas_pkg::DONE_BIT]; // clear only
        end
        case (state_ff)
            adcas_pkg::ADCAS_SYNC: begin
                if (tick) begin
                    nxt_state   = adcas_pkg::ADCAS_CONV;
                    nxt_bit_cnt = 4'h0;
                end
            end
            adcas_pkg::ADCAS_CONV: begin
                if (tick) begin
                    nxt_bit_cnt = bit_cnt_ff + 4'h1;
                    if (bit_cnt_ff == adcas_pkg::SAMPLE_TICKS - 4'h1) begin
                        nxt_sar = adcas_pkg::SAR_MSB;
                    end else if (bit_cnt_ff >= adcas_pkg::SAMPLE_TICKS) begin
                        nxt_sar[bit_idx] = cmp_i;
                        if (bit_idx != 4'h0) begin
                            nxt_sar[bit_idx - 4'h1] = 1'b1;
                        end
                    end
                    if (bit_cnt_ff == adcas_pkg::CONV_TICKS - 4'h1) begin
                        nxt_state = adcas_pkg::ADCAS_STORE;
                    end
                end
            end
            adcas_pkg::ADCAS_STORE: begin
                nxt_init_cnt = 3'h1;
                nxt_state    = adcas_pkg::ADCAS_INIT;
                nxt_ch       = hi_ch;
                if (last_ch) begin
                    nxt_done = 1'b1; // set wins over a same-cycle clear
                    if (cont_ff && mask_ff != 8'h00) begin
                        nxt_act = mask_ff;
                        nxt_ch  = lo_ch;
                    end else begin
                        nxt_start = 1'b0;
                        nxt_state = adcas_pkg::ADCAS_IDLE;
                    end
                end
            end
            adcas_pkg::ADCAS_INIT: begin
                nxt_init_cnt = init_cnt_ff + 3'h1;
                if (init_cnt_ff == {pre_sel_ff, 1'b1}) begin // divisor minus one cycles
                    nxt_state   = adcas_pkg::ADCAS_CONV;
                    nxt_bit_cnt = 4'h0;
                    nxt_pre_cnt = 2'h0;
                end
            end
            default: begin
                nxt_state = adcas_pkg::ADCAS_IDLE;
            end
        endcase
        if (ctrl_wr_i && ctrl_wdata_i[adcas_pkg::START_BIT]) begin
            if (done_ff) begin
                nxt_pend = !start_ff; // held behind done flag
            end else if (!start_ff && mask_ff != 8'h00) begin
                go = 1'b1;
            end
        end else if (ctrl_wr_i) begin
            nxt_start = 1'b0; // abort
            nxt_pend  = 1'b0;
            nxt_state = adcas_pkg::ADCAS_IDLE;
        end
        if (ext_edge && !done_ff && !start_ff && mask_ff != 8'h00) begin
            go = 1'b1;
        end
        if (pend_ff && !done_ff && !start_ff) begin
            nxt_pend = 1'b0;
            go       = lo_any; // empty mask drops the held start
        end
        if (go) begin
            nxt_start = 1'b1;
            nxt_act   = mask_ff;
            nxt_ch    = lo_ch;
            nxt_state = adcas_pkg::ADCAS_SYNC;
        end
        if (pwr_down_i) begin
            nxt_start   = 1'b0; // done flag and results kept
            nxt_pend    = 1'b0;
            nxt_state   = adcas_pkg::ADCAS_IDLE;
            nxt_pre_cnt = pre_cnt_ff; // divider halted
        end
    end
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_ff    <= adcas_pkg::ADCAS_IDLE;
            pre_sel_ff  <= adcas_pkg::CTRL_RST[adcas_pkg::PRE_HI_BIT:adcas_pkg::PRE_LO_BIT];
            done_ff     <= adcas_pkg::CTRL_RST[adcas_pkg::DONE_BIT];
            start_ff    <= adcas_pkg::CTRL_RST[adcas_pkg::START_BIT];
            pend_ff     <= 1'b0;
            cont_ff     <= adcas_pkg::CTRL_RST[adcas_pkg::CONT_BIT];
            rise_en_ff  <= adcas_pkg::CTRL_RST[adcas_pkg::RISE_BIT];
            fall_en_ff  <= adcas_pkg::CTRL_RST[adcas_pkg::FALL_BIT];
            mask_ff     <= adcas_pkg::MASK_RST;
            act_ff      <= adcas_pkg::MASK_RST;
            ch_ff       <= '0;
            pre_cnt_ff  <= 2'h0;
            bit_cnt_ff  <= 4'h0;
            init_cnt_ff <= 3'h0;
            sar_ff      <= '0;
        end else begin
            state_ff    <= nxt_state;
            pre_sel_ff  <= nxt_pre_sel;
            done_ff     <= nxt_done;
            start_ff    <= nxt_start;
            pend_ff     <= nxt_pend;
            cont_ff     <= nxt_cont;
            rise_en_ff  <= nxt_rise_en;
            fall_en_ff  <= nxt_fall_en;
            mask_ff     <= nxt_mask;
            act_ff      <= nxt_act;
            ch_ff       <= nxt_ch;
            pre_cnt_ff  <= nxt_pre_cnt;
            bit_cnt_ff  <= nxt_bit_cnt;
            init_cnt_ff <= nxt_init_cnt;
            sar_ff      <= nxt_sar;
        end
    end
    // start bit shows the effective state, never the held request
    assign conv_control_reg_o = {pre_sel_ff, 1'b0, done_ff, start_ff, cont_ff,
                                 rise_en_ff, fall_en_ff};
    assign scan_select_mask_o = mask_ff;
    assign dac_code_o         = sar_ff;
    assign ch_sel_o           = ch_ff;
    assign sample_o           = (state_ff == adcas_pkg::ADCAS_CONV) &&
                                (bit_cnt_ff < adcas_pkg::SAMPLE_TICKS);
    adcas_result_mem u_mem (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .wr_en_i   (store_en),
        .wr_ch_i   (ch_ff),
        .wr_data_i (sar_ff),
        .rd_ch_i   (rd_ch_i),
        .rd_data_o (rd_data_o)
    );
    // helper: cycles since the first cycle of a conversion; m_val is the divisor
    adcas_pkg::adcas_state_e prev_state_ff;
    logic [5:0] gap_ff;
    logic [5:0] m_val;
    assign m_val = {3'h0, pre_sel_ff, 1'b0} + 6'h2;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            prev_state_ff <= adcas_pkg::ADCAS_IDLE;
            gap_ff        <= 6'h0;
        end else begin
            prev_state_ff <= state_ff;
            if (state_ff == adcas_pkg::ADCAS_CONV && prev_state_ff != adcas_pkg::ADCAS_CONV) begin
                gap_ff <= 6'h1;
            end else if (gap_ff != 6'h3F) begin
                gap_ff <= gap_ff + 6'h1;
            end
        end
    end
    a_conv_length: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (state_ff == adcas_pkg::ADCAS_STORE) |-> (gap_ff == m_val * 6'h6))
        else $error("conversion length wrong");
    a_loop_spacing: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (state_ff == adcas_pkg::ADCAS_CONV && prev_state_ff == adcas_pkg::ADCAS_INIT)
        |-> (gap_ff == m_val * 6'h7))
        else $error("conversion spacing wrong");
    a_done_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (store_en && last_ch) |=> done_ff) else $error("done flag not set at loop end");
    a_start_inhibit: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (done_ff && !start_ff) ##1 done_ff |-> !start_ff) else $error("start taken while done set");
    a_single_stop: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (store_en && last_ch && !cont_ff && !ctrl_wr_i && !ext_edge && !pend_ff)
        |=> (!start_ff && state_ff == adcas_pkg::ADCAS_IDLE))
        else $error("single pass did not stop");
    a_cont_keep: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (store_en && last_ch && cont_ff && mask_ff != 8'h00 && !ctrl_wr_i && !pwr_down_i)
        |=> (start_ff && ch_ff == $past(lo_ch)))
        else $error("continuous loop did not restart");
    a_pwrdn_abort: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        pwr_down_i |=> (!start_ff && state_ff == adcas_pkg::ADCAS_IDLE && done_ff == $past(done_ff)))
        else $error("power down did not abort");
    a_zero_mask: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (mask_ff == 8'h00 && !start_ff) |=> !start_ff) else $error("start with empty mask");
    a_pend_read: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (pend_ff && done_ff) |-> !conv_control_reg_o[adcas_pkg::START_BIT])
        else $error("pending start visible");
endmodule // adcas_sequencer
`default_nettype wire

// ===== adcas_analog_model.sv
// far side model: eight analog inputs at fixed levels and the comparator
`timescale 1ns/1ps
`default_nettype none
module adcas_analog_model (
    input  wire logic [9:0] dac_code_i,
    input  wire logic [2:0] ch_sel_i,
    input  wire logic       sample_i,
    output logic            cmp_o
);
    logic [9:0] level;
    logic       raw;
    // every channel has its own level, so a wrong channel shows in the result
    assign level = {ch_sel_i, 7'h2B};
    assign raw   = (level >= dac_code_i);
    // while sampling the comparator answer is not usable, so it is inverted
    assign cmp_o = sample_i ? ~raw : raw;
endmodule // adcas_analog_model
`default_nettype wire

// ===== tb_adc_autoscan_sequencer.sv
// self-checking bench for the autoscan sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_adc_autoscan_sequencer;
    logic       clk_i           = 1'b0;
    logic       sys_rst_i       = 1'b1;
    logic       ctrl_wr_i       = 1'b0;
    logic [7:0] ctrl_wdata_i    = 8'h00;
    logic       mask_wr_i       = 1'b0;
    logic [7:0] mask_wdata_i    = 8'h00;
    logic       pwr_down_i      = 1'b0;
    logic       ext_start_pin_i = 1'b0;
    logic [2:0] rd_ch_i         = 3'h0;
    logic       cmp_i;
    logic [7:0] ctrl_o;
    logic [7:0] mask_o;
    logic [9:0] dac_code_o;
    logic [9:0] rd_data_o;
    logic [2:0] ch_sel_o;
    logic       sample_o;
    int         n_mismatch = 0;
    int         compares   = 0;
    int         cyc        = 0;
    int         run        = 0;
    int         t_wr, t_dn, m, k, c, e, v;
    int         q_t[$];
    int         q_ch[$];
    int         q_w[$];
    // rows: expected divisor, prescale code, scan mask
    localparam logic [13:0] ROWS [4] = '{14'h0801, 14'h11A5, 14'h1A80, 14'h230F};

    adcas_sequencer adcas_sequencer_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .ctrl_wr_i(ctrl_wr_i), .ctrl_wdata_i(ctrl_wdata_i), .conv_control_reg_o(ctrl_o),
        .mask_wr_i(mask_wr_i), .mask_wdata_i(mask_wdata_i), .scan_select_mask_o(mask_o),
        .pwr_down_i(pwr_down_i), .ext_start_pin_i(ext_start_pin_i), .cmp_i(cmp_i),
        .dac_code_o(dac_code_o), .ch_sel_o(ch_sel_o), .sample_o(sample_o),
        .rd_ch_i(rd_ch_i), .rd_data_o(rd_data_o));
    adcas_analog_model adcas_analog_model_inst (.dac_code_i(dac_code_o),
        .ch_sel_i(ch_sel_o), .sample_i(sample_o), .cmp_o(cmp_i));

    always #2 clk_i = ~clk_i;
    always @(posedge clk_i) cyc <= cyc + 1;
    // records start cycle, channel and length of each sample window
    always @(posedge clk_i) begin
        if (sample_o === 1'b1) begin
            if (run == 0) begin
                q_t.push_back(cyc);
                q_ch.push_back(int'(ch_sel_o));
            end
            run = run + 1;
        end else if (run != 0) begin
            q_w.push_back(run);
            run = 0;
        end
    end

    function automatic logic [9:0] lvl(int ch);
        return {ch[2:0], 7'h2B};
    endfunction
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(string nm, int ex, logic [9:0] g);
        compares++;
        if (g !== ex[9:0]) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, ex[9:0], g);
        end
    endtask
    task automatic idle(int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic clr_q();
        q_t.delete();
        q_ch.delete();
        q_w.delete();
    endtask
    // one write pulse; the mask port when msk is set, else the control port
    task automatic wr(bit msk, logic [7:0] d);
        @(posedge clk_i);
        #1;
        mask_wr_i    = msk;
        ctrl_wr_i    = ~msk;
        mask_wdata_i = d;
        ctrl_wdata_i = d;
        @(posedge clk_i);
        #1;
        mask_wr_i = 1'b0;
        ctrl_wr_i = 1'b0;
        t_wr = cyc;
    endtask
    task automatic wait_done(int lim);
        for (int i = 0; i < lim && ctrl_o[4] !== 1'b1; i++) idle(1);
        t_dn = cyc;
        if (ctrl_o[4] !== 1'b1) begin
            n_mismatch++;
            $display("BAD done flag expected 1 seen %b", ctrl_o[4]);
            wrap_up();
        end
    endtask

    initial begin
        idle(8);
        sys_rst_i = 1'b0;
        chk("ctrl reset", 0, ctrl_o);
        chk("mask reset", 0, mask_o);
        foreach (ROWS[r]) begin
            m = ROWS[r][13:10];
            clr_q();
            wr(1'b1, ROWS[r][7:0]);
            wr(1'b0, {ROWS[r][9:8], 6'h18});
            wait_done(800);
            chk("start", 0, ctrl_o[3]);
            chk("first", 1, 10'(q_t[0] - t_wr <= m / 2));
            chk("tconv", 6 * m + 1, 10'(t_dn - q_t[q_t.size() - 1]));
            chk("width", m, 10'(q_w[0]));
            k = 0;
            for (c = 0; c < 8; c++) begin
                if (ROWS[r][c]) begin
                    v = c;
                    chk("chan", c, 10'(q_ch[k]));
                    if (k > 0) chk("gap", 7 * m, 10'(q_t[k] - q_t[k - 1]));
                    rd_ch_i = c[2:0];
                    idle(2);
                    chk("result", int'(lvl(c)), rd_data_o);
                    k++;
                end
            end
            chk("count", k, 10'(q_t.size()));
            chk("dac", int'(lvl(v)), dac_code_o);
            wr(1'b0, 8'h00);
            idle(1);
            chk("done clear", 0, ctrl_o[4]);
            $display("row %0d done", r);
        end
        // continuous loop; a mask write inside the loop waits for the next one
        clr_q();
        wr(1'b1, 8'h03);
        wr(1'b0, 8'h1C);
        wr(1'b1, 8'h01);
        wait_done(200);
        chk("loop1 count", 2, 10'(q_ch.size()));
        chk("loop1 chan", 1, 10'(q_ch[1]));
        chk("cont start", 1, ctrl_o[3]);
        clr_q();
        wr(1'b0, 8'h0C);
        wait_done(200);
        chk("loop2", 1, 10'(q_ch.size() > 0 && q_ch[0] == 0));
        chk("cont start", 1, ctrl_o[3]);
        pwr_down_i = 1'b1;
        idle(2);
        chk("pd start", 0, ctrl_o[3]);
        chk("pd done", 1, ctrl_o[4]);
        pwr_down_i = 1'b0;
        $display("continuous and power-down done");
        // start written behind a set done flag is held and hidden
        clr_q();
        wr(1'b0, 8'h18);
        idle(30);
        chk("held start", 0, ctrl_o[3]);
        chk("held runs", 0, 10'(q_t.size()));
        chk("done kept", 1, ctrl_o[4]);
        wr(1'b0, 8'h08);
        wait_done(200);
        chk("held scan", 1, 10'(q_t.size()));
        wr(1'b1, 8'h00);
        wr(1'b0, 8'h08);
        idle(20);
        chk("zero mask", 0, {ctrl_o[4], ctrl_o[3]});
        wr(1'b1, 8'h01);
        wr(1'b0, 8'hC8);
        idle(10);
        wr(1'b0, 8'hC0);
        idle(1);
        chk("abort start", 0, ctrl_o[3]);
        idle(80);
        chk("abort done", 0, ctrl_o[4]);
        $display("held start, zero mask and abort done");
        // pin goes 0 to 1 then 1 to 0; only the enabled edge may start
        for (e = 0; e < 2; e++) begin
            wr(1'b0, e ? 8'h11 : 8'h12);
            for (v = 1; v >= 0; v--) begin
                ext_start_pin_i = v[0];
                idle(8);
                chk("ext start", int'((v == 1) == (e == 0)), ctrl_o[3] | ctrl_o[4]);
                if ((v == 1) == (e == 0)) begin
                    wait_done(100);
                    wr(1'b0, e ? 8'h01 : 8'h02);
                end
            end
        end
        $display("external start done");
        sys_rst_i = 1'b1;
        idle(2);
        sys_rst_i = 1'b0;
        chk("ctrl reset", 0, ctrl_o);
        chk("mask reset", 0, mask_o);
        $display("reset done");
        wrap_up();
    end
endmodule // tb_adc_autoscan_sequencer
`default_nettype wire
